// [design/spio_port.sv]
// Sequencer parallel I/O port: output byte, input tests, fixture control lines
`timescale 1ns/1ps
module spio_port (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire spio_pkg::spio_req_t req,
  output logic [7:0]              rdata,
  input  wire logic [4:0]         par_in,
  input  wire logic               dir_fwd,
  output logic [7:0]              par_out,
  output logic                    gpio_mode,
  output logic [2:0]              fixture_ctl,
  output logic                    fixture_valid_b
);
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic [2:0] fwd_q;
  logic [2:0] fwd_d;
  logic [2:0] rev_q;
  logic [2:0] rev_d;
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic       mode_q;
  logic       mode_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic [7:0] par_q;
  logic [7:0] par_d;
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;
  logic [4:0] in_q;
  logic [4:0] in_d;
  logic       dir1_q;
  logic       dir2_q;
  logic       dir3_q;
  logic       dir_q;
  logic       dir_d;
  logic [2:0] ctl_q;
  logic [2:0] ctl_d;
  logic       val_b_q;
  logic       val_b_d;
  logic       in_bit;

  // Three-stage sampling; a change is taken once stages two and three agree.
  // The first stage may go metastable, so only the second stage reads it.
  always_comb
  begin
    in_d = in_q;
    for (int i = 0; i < 5; i++)
    begin
      if (s2_q[i] == s3_q[i])
        in_d[i] = s3_q[i];
    end
    dir_d = dir_q;
    if (dir2_q == dir3_q)
      dir_d = dir3_q;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q   <= 5'h00;
      s2_q   <= 5'h00;
      s3_q   <= 5'h00;
      in_q   <= 5'h00;
      // Direction comes up forward so the first control value is the forward one
      dir1_q <= 1'b1;
      dir2_q <= 1'b1;
      dir3_q <= 1'b1;
      dir_q  <= 1'b1;
    end
    else
    begin
      s1_q   <= par_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      in_q   <= in_d;
      dir1_q <= dir_fwd;
      dir2_q <= dir1_q;
      dir3_q <= dir2_q;
      dir_q  <= dir_d;
    end
  end

  // Shared by set and clear so both touch exactly one line of the byte
  function automatic logic [7:0] bit_put(
    input logic [7:0] byte_in,
    input logic [2:0] idx,
    input logic       val
  );
    logic [7:0] res;
    res      = byte_in;
    res[idx] = val;
    return res;
  endfunction

  assign in_bit = in_q[sel_q];

  always_comb
  begin
    out_d  = out_q;
    fwd_d  = fwd_q;
    rev_d  = rev_q;
    sel_d  = sel_q;
    mode_d = mode_q;
    rd_d   = 8'h00;
    if (req.wr)
    begin
      if (req.addr == spio_pkg::ADDR_MODE)
        mode_d = req.wdata[0];
      else if (req.addr == spio_pkg::ADDR_OUT_ALL && mode_q)
        out_d = req.wdata;
      else if (req.addr == spio_pkg::ADDR_SET_BIT && mode_q)
        out_d = bit_put(out_q, req.wdata[2:0], 1'b1);
      else if (req.addr == spio_pkg::ADDR_CLR_BIT && mode_q)
        out_d = bit_put(out_q, req.wdata[2:0], 1'b0);
      else if (req.addr == spio_pkg::ADDR_IN_SEL && req.wdata[2:0] <= spio_pkg::MAX_SEL)
        sel_d = req.wdata[2:0];
      else if (req.addr == spio_pkg::ADDR_CTL_FWD)
        fwd_d = req.wdata[2:0];
      else if (req.addr == spio_pkg::ADDR_CTL_REV)
        rev_d = req.wdata[2:0];
    end
    if (req.rd)
    begin
      if (req.addr == spio_pkg::ADDR_MODE)
        rd_d = {7'h00, mode_q};
      else if (req.addr == spio_pkg::ADDR_OUT_ALL)
        rd_d = out_q;
      else if (req.addr == spio_pkg::ADDR_IN_SEL)
        rd_d = {5'h00, sel_q};
      else if (req.addr == spio_pkg::ADDR_TEST_HI)
        rd_d = {7'h00, mode_q & in_bit};
      else if (req.addr == spio_pkg::ADDR_TEST_LO)
        rd_d = {7'h00, mode_q & ~in_bit};
      else if (req.addr == spio_pkg::ADDR_CTL_FWD)
        rd_d = {5'h00, fwd_q};
      else if (req.addr == spio_pkg::ADDR_CTL_REV)
        rd_d = {5'h00, rev_q};
      else if (req.addr == spio_pkg::ADDR_IN_RAW)
        rd_d = {3'h0, in_q};
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q  <= spio_pkg::RST_OUT;
      fwd_q  <= spio_pkg::RST_CTL;
      rev_q  <= spio_pkg::RST_CTL;
      sel_q  <= spio_pkg::RST_SEL;
      mode_q <= spio_pkg::RST_MODE;
      rd_q   <= 8'h00;
    end
    else
    begin
      out_q  <= out_d;
      fwd_q  <= fwd_d;
      rev_q  <= rev_d;
      sel_q  <= sel_d;
      mode_q <= mode_d;
      rd_q   <= rd_d;
    end
  end

  // Output byte is registered so the pins never see decode glitches;
  // copy mode forces every line low
  always_comb
  begin
    par_d = mode_d ? out_d : 8'h00;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      par_q <= spio_pkg::RST_OUT;
    else
      par_q <= par_d;
  end

  // Strobe drops out for one cycle whenever the lines change, so a latch never sees a glitch
  always_comb
  begin
    ctl_d   = dir_q ? fwd_q : rev_q;
    val_b_d = (ctl_d != ctl_q);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_q   <= spio_pkg::RST_CTL;
      val_b_q <= 1'b1;
    end
    else
    begin
      ctl_q   <= ctl_d;
      val_b_q <= val_b_d;
    end
  end

  assign rdata           = rd_q;
  assign par_out         = par_q;
  assign gpio_mode       = mode_q;
  assign fixture_ctl     = ctl_q;
  assign fixture_valid_b = val_b_q;

  AST_SET_BIT: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && mode_q && req.addr == spio_pkg::ADDR_SET_BIT |=> out_q[$past(req.wdata[2:0])])
    else $error("set bit did not drive line high");
  AST_CLR_BIT: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && mode_q && req.addr == spio_pkg::ADDR_CLR_BIT |=> !out_q[$past(req.wdata[2:0])])
    else $error("clear bit did not drive line low");
  AST_ALL: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && mode_q && req.addr == spio_pkg::ADDR_OUT_ALL |=> out_q == $past(req.wdata))
    else $error("byte write lost");
  AST_MODE: assert property (@(posedge clk) disable iff (!rst_b) !mode_q |-> par_out == 8'h00)
    else $error("outputs driven outside general purpose mode");
  AST_SEL: assert property (@(posedge clk) disable iff (!rst_b) sel_q <= spio_pkg::MAX_SEL)
    else $error("selector out of range");
  AST_TEST_HI: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == spio_pkg::ADDR_TEST_HI |=> rdata[0] == $past(mode_q & in_bit))
    else $error("high test wrong");
  AST_TEST_LO: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == spio_pkg::ADDR_TEST_LO |=> rdata[0] == $past(mode_q & ~in_bit))
    else $error("low test wrong");
  AST_DIR: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> fixture_ctl == $past(dir_q ? fwd_q : rev_q))
    else $error("control lines not following direction");
  AST_VALID: assert property (@(posedge clk) disable iff (!rst_b)
    !fixture_valid_b |-> $stable(fixture_ctl))
    else $error("valid strobe low while lines changed");
  AST_SYNC: assert property (@(posedge clk) disable iff (!rst_b)
    (s2_q == s3_q) |=> in_q == $past(s3_q))
    else $error("input not taken after agreement");

  // Bit commands touch one line and leave the other seven as they were
  AST_SET_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && mode_q && req.addr == spio_pkg::ADDR_SET_BIT
      |=> out_q == ($past(out_q) | (8'h01 << $past(req.wdata[2:0]))))
    else $error("set bit disturbed other lines");
  AST_CLR_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && mode_q && req.addr == spio_pkg::ADDR_CLR_BIT
      |=> out_q == ($past(out_q) & ~(8'h01 << $past(req.wdata[2:0]))))
    else $error("clear bit disturbed other lines");
  AST_COPY_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && !mode_q && (req.addr == spio_pkg::ADDR_OUT_ALL
      || req.addr == spio_pkg::ADDR_SET_BIT || req.addr == spio_pkg::ADDR_CLR_BIT)
      |=> $stable(out_q))
    else $error("output byte changed in copy mode");
  AST_MODE_WR: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == spio_pkg::ADDR_MODE |=> gpio_mode == $past(req.wdata[0]))
    else $error("mode write lost");
  AST_PAR_OUT: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q |-> par_out == out_q)
    else $error("output lines differ from stored byte");

  // Selector and read-back paths
  AST_SEL_WR: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == spio_pkg::ADDR_IN_SEL && req.wdata[2:0] <= spio_pkg::MAX_SEL
      |=> sel_q == $past(req.wdata[2:0]))
    else $error("selector write lost");
  AST_SEL_REFUSE: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == spio_pkg::ADDR_IN_SEL && req.wdata[2:0] > spio_pkg::MAX_SEL
      |=> $stable(sel_q))
    else $error("out of range selector taken");
  AST_RD_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == spio_pkg::ADDR_IN_SEL |=> rdata == {5'h00, $past(sel_q)})
    else $error("selector read wrong");
  AST_RD_OUT: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == spio_pkg::ADDR_OUT_ALL |=> rdata == $past(out_q))
    else $error("output byte read wrong");
  AST_RAW: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == spio_pkg::ADDR_IN_RAW |=> rdata == {3'h0, $past(in_q)})
    else $error("raw input read wrong");

  // Fixture control values and direction
  AST_FWD_WR: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == spio_pkg::ADDR_CTL_FWD |=> fwd_q == $past(req.wdata[2:0]))
    else $error("forward value write lost");
  AST_REV_WR: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == spio_pkg::ADDR_CTL_REV |=> rev_q == $past(req.wdata[2:0]))
    else $error("reverse value write lost");
  AST_RD_FWD: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == spio_pkg::ADDR_CTL_FWD |=> rdata == {5'h00, $past(fwd_q)})
    else $error("forward value read wrong");
  AST_RD_REV: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == spio_pkg::ADDR_CTL_REV |=> rdata == {5'h00, $past(rev_q)})
    else $error("reverse value read wrong");
  AST_DIR_SYNC: assert property (@(posedge clk) disable iff (!rst_b)
    (dir2_q == dir3_q) |=> dir_q == $past(dir3_q))
    else $error("direction not taken after agreement");

  // Strobe and sampler timing
  AST_VALID_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(fixture_ctl) |-> fixture_valid_b)
    else $error("valid strobe low while lines moved");
  AST_VALID_RETURN: assert property (@(posedge clk) disable iff (!rst_b)
    fixture_valid_b |=> !fixture_valid_b || $changed(fixture_ctl))
    else $error("valid strobe did not return low");
  AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    (s2_q[0] != s3_q[0]) |=> $stable(in_q[0]))
    else $error("input taken before agreement");
endmodule

// [inc/spio_pkg.sv]
// Package for the sequencer parallel I/O port: constants, commands and carriers
// Behaviour
// - The port works as general purpose I/O only while general purpose mode, not printer copy mode, is selected.
// - A whole-byte write drives all eight output lines with the binary form of a value 0 to 255 at once.
// - A set-bit command with index 0 to 7 drives that output line high and leaves the other seven alone.
// - A clear-bit command with index 0 to 7 drives that output line low and leaves the other seven alone.
// - Five input lines exist, and a selector holding 0 to 4 picks the line that later tests examine.
// - A test-if-high reports true, causing a jump, exactly when the selected input is sampled high.
// - A test-if-low reports true, causing a jump, exactly when the selected input is sampled low.
// - Separate forward and reverse 3-bit fixture control values are held and the one for the current direction is driven.
// - The fixture control output is plain binary with line 0 least significant and line 2 most significant.
// - An active-low valid strobe is driven while the fixture control lines are stable so the far side may latch them.
package spio_pkg;
  localparam int OUT_W = 8;
  localparam int IN_W  = 5;
  localparam int CTL_W = 3;

  // Register offsets on the plain command port
  localparam logic [3:0] ADDR_MODE     = 4'h0;
  localparam logic [3:0] ADDR_OUT_ALL  = 4'h1;
  localparam logic [3:0] ADDR_SET_BIT  = 4'h2;
  localparam logic [3:0] ADDR_CLR_BIT  = 4'h3;
  localparam logic [3:0] ADDR_IN_SEL   = 4'h4;
  localparam logic [3:0] ADDR_TEST_HI  = 4'h5;
  localparam logic [3:0] ADDR_TEST_LO  = 4'h6;
  localparam logic [3:0] ADDR_CTL_FWD  = 4'h7;
  localparam logic [3:0] ADDR_CTL_REV  = 4'h8;
  localparam logic [3:0] ADDR_IN_RAW   = 4'h9;

  localparam logic [7:0] RST_OUT   = 8'h00;
  localparam logic [2:0] RST_CTL   = 3'h0;
  localparam logic [2:0] RST_SEL   = 3'h0;
  localparam logic       RST_MODE  = 1'b0;
  localparam logic [2:0] MAX_SEL   = 3'h4;
  // Cycles the strobe stays high after a control change before reasserting
  localparam int         SETTLE_CYC = 1;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spio_req_t;
endpackage

// [sim/spio_fixture.sv]
// Fixture model: drives the input lines and latches the control lines
`timescale 1ns/1ps
module spio_fixture (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [4:0] drive_val,
  output logic      [4:0] par_in,
  input  wire logic [2:0] fixture_ctl,
  input  wire logic       fixture_valid_b,
  output logic      [2:0] latched_q
);
  assign par_in = drive_val;
  // Latches only under the strobe, so a skewed change is never captured
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      latched_q <= 3'h0;
    else if (!fixture_valid_b)
      latched_q <= fixture_ctl;
  end
endmodule

// [sim/test_sequencer_parallel_io_port.sv]
// Self-checking bench for the sequencer parallel I/O port
`timescale 1ns/1ps
module test_sequencer_parallel_io_port;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                dir_fwd = 1'b1;
  logic [4:0]          drive_val = 5'h00;
  spio_pkg::spio_req_t req = '0;
  logic [7:0]          rdata, par_out, q;
  logic [4:0]          par_in;
  logic [2:0]          fixture_ctl, latched_q;
  logic                gpio_mode, fixture_valid_b;
  int                  err_total = 0, total_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  spio_port dut (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .par_in(par_in),
    .dir_fwd(dir_fwd), .par_out(par_out), .gpio_mode(gpio_mode),
    .fixture_ctl(fixture_ctl), .fixture_valid_b(fixture_valid_b));
  spio_fixture fix (.clk(clk), .rst_b(rst_b), .drive_val(drive_val), .par_in(par_in),
    .fixture_ctl(fixture_ctl), .fixture_valid_b(fixture_valid_b), .latched_q(latched_q));
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(nm, exp, rdata);
  endtask
  // Test result sits in bit 0; the other bits read zero and are not compared
  task automatic tst(input logic [3:0] a, input logic exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk("test", {7'h00, exp}, {7'h00, rdata[0]});
  endtask
  task automatic t_out;
    chk("reset out", 8'h00, par_out);
    chk("reset mode", 8'h00, {7'h00, gpio_mode});
    rd(spio_pkg::ADDR_IN_SEL, 8'h00, "reset sel");
    wr(spio_pkg::ADDR_OUT_ALL, 8'hFF);
    chk("copy mode out", 8'h00, par_out);
    wr(spio_pkg::ADDR_MODE, 8'h01);
    chk("gpio mode", 8'h01, {7'h00, gpio_mode});
    wr(spio_pkg::ADDR_OUT_ALL, 8'hA5);
    chk("byte", 8'hA5, par_out);
    rd(spio_pkg::ADDR_OUT_ALL, 8'hA5, "byte read");
    wr(spio_pkg::ADDR_OUT_ALL, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(spio_pkg::ADDR_SET_BIT, 8'(i));
      chk("set", 8'((2 << i) - 1), par_out);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(spio_pkg::ADDR_CLR_BIT, 8'(i));
      chk("clear", 8'(8'hFF << (i + 1)), par_out);
    end
  endtask
  task automatic t_in;
    wr(spio_pkg::ADDR_IN_SEL, 8'h04);
    @(posedge clk);
    drive_val <= 5'h10;
    repeat (6) @(posedge clk);
    tst(spio_pkg::ADDR_TEST_HI, 1'b1);
    tst(spio_pkg::ADDR_TEST_LO, 1'b0);
    @(posedge clk);
    drive_val <= 5'h0F;
    repeat (6) @(posedge clk);
    wr(spio_pkg::ADDR_IN_SEL, 8'h05);
    rd(spio_pkg::ADDR_IN_SEL, 8'h04, "sel refused");
    rd(spio_pkg::ADDR_IN_RAW, 8'h0F, "raw inputs");
    tst(spio_pkg::ADDR_TEST_HI, 1'b0);
    tst(spio_pkg::ADDR_TEST_LO, 1'b1);
    // A one-cycle pulse must not reach the tests
    @(posedge clk);
    drive_val <= 5'h1F;
    @(posedge clk);
    drive_val <= 5'h0F;
    repeat (6) @(posedge clk);
    tst(spio_pkg::ADDR_TEST_HI, 1'b0);
  endtask
  task automatic t_ctl;
    chk("reset ctl", 8'h00, {5'h00, fixture_ctl});
    wr(spio_pkg::ADDR_CTL_FWD, 8'h06);
    wr(spio_pkg::ADDR_CTL_REV, 8'h01);
    repeat (4) @(posedge clk);
    #1 chk("fwd ctl", 8'h06, {5'h00, fixture_ctl});
    chk("fwd latched", 8'h06, {5'h00, latched_q});
    rd(spio_pkg::ADDR_CTL_FWD, 8'h06, "fwd read");
    rd(spio_pkg::ADDR_CTL_REV, 8'h01, "rev read");
    @(posedge clk);
    dir_fwd <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("rev ctl", 8'h01, {5'h00, fixture_ctl});
    chk("rev latched", 8'h01, {5'h00, latched_q});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_out();
    t_in();
    t_ctl();
    give_verdict();
  end
endmodule
